// [design/pit_map.svh]
`ifndef PIT_MAP_SVH
`define PIT_MAP_SVH
// Register regions, selected by address bits 11:8
`define PIT_RG_GLB 4'h0
`define PIT_RG_THR 4'h1
`define PIT_RG_MCTL 4'h2
`define PIT_RG_IEN 4'h3
// Word index inside the global region, address bits 7:2
`define PIT_IX_START 6'h00
`define PIT_IX_NCEN 6'h01
`define PIT_IX_GCTL 6'h02
`define PIT_IX_LVL 6'h03
`define PIT_IX_RUN 6'h04
// Global control bits
`define PIT_GC_EN 0
`define PIT_GC_PRE 1
// Mode control fields
`define PIT_CK_HI 7
`define PIT_CK_LO 5
`define PIT_MD_HI 4
`define PIT_MD_LO 2
`define PIT_EG_HI 1
`define PIT_EG_LO 0
`define PIT_CK_LAST 3'h5
// Measurement modes
`define PIT_MD_HILO 3'h2
`define PIT_MD_PWM 3'h4
`define PIT_MD_ROT 3'h5
`define PIT_MD_UPDN 3'h6
`define PIT_MD_X4 3'h7
// Edge sense codes
`define PIT_EG_NONE 2'h0
`define PIT_EG_RISE 2'h1
`define PIT_EG_FALL 2'h2
`define PIT_EG_BOTH 2'h3
// Interrupt enable bits
`define PIT_IE_C 3
`define PIT_IE_B 2
`define PIT_IE_A 1
`define PIT_IE_CAP 0
// Reset values
`define PIT_RST_W32 32'h0000_0000
`define PIT_RST_B8 8'h00
`define PIT_RST_IE 4'h0
`endif

// [design/pit_pkg.sv]
package pit_pkg;
  typedef enum logic {PH_LOW, PH_HIGH} pit_phase_type;
endpackage

// [design/pit_noise_filter.sv]
`timescale 1ns/1ps
module pit_noise_filter
  import pit_pkg::*;
#(
  parameter int TH_W = 16
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic din_i,
  input wire logic en_i,
  input wire logic pre_i,
  input wire logic [TH_W-1:0] thr_i,
  output logic dout_o,
  output logic busy_o
);
  logic out_q;
  logic busy_q;
  logic cand_q;
  logic pre_q;
  logic [TH_W-1:0] cnt_q;

  // ----------------------------------------
  // Filter state
  // ----------------------------------------
  // A run, once started, is finished even if the enable drops meanwhile
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      out_q <= 1'b0;
      busy_q <= 1'b0;
      cand_q <= 1'b0;
      pre_q <= 1'b0;
      cnt_q <= '0;
    end else if (clr_i) begin
      out_q <= 1'b0;
      busy_q <= 1'b0;
      cnt_q <= '0;
    end else if (!busy_q) begin
      if (din_i != out_q) begin
        if (en_i) begin
          busy_q <= 1'b1; // R08
          cnt_q <= '0;
          cand_q <= din_i;
          pre_q <= pre_i;
          if (!pre_i) begin
            out_q <= din_i; // R09
          end
        end else begin
          out_q <= din_i;
        end
      end
    end else if (pre_q && din_i != cand_q) begin
      busy_q <= 1'b0; // R10 R12
    end else if (cnt_q == thr_i) begin
      out_q <= din_i; // R09 R10
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 1'b1; // R11
    end
  end

  assign dout_o = out_q;
  assign busy_o = busy_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_sub_pass;
    @(posedge mclk_i) disable iff (rst_i)
    !busy_q && en_i && !pre_i && !clr_i && din_i != out_q |=> out_q == $past(din_i) && busy_q;
  endproperty
  a_sub_pass: assert property (p_sub_pass) else $error("subsequent edge not passed"); // R09

  property p_pre_hold;
    @(posedge mclk_i) disable iff (rst_i)
    !busy_q && en_i && pre_i && !clr_i && din_i != out_q |=> out_q == $past(out_q) && busy_q;
  endproperty
  a_pre_hold: assert property (p_pre_hold) else $error("preceding edge passed early"); // R10

  property p_sub_mask;
    @(posedge mclk_i) disable iff (rst_i)
    busy_q && !pre_q && !clr_i && cnt_q != thr_i |=> out_q == $past(out_q) && busy_q;
  endproperty
  a_sub_mask: assert property (p_sub_mask) else $error("change not masked"); // R11

  c_pre_pass: cover property (@(posedge mclk_i) busy_q && pre_q && cnt_q == thr_i);
endmodule // pit_noise_filter

// [design/pit_top.sv]
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "pit_map.svh"
// Operation
// (R01) Count only with run bit and master enable
// (R02) Run bits 19:0, upper bits read zero
// (R03) Stopped counters hold, resume from held value
// (R04) Prescaler free-running, never reset by start
// (R05) Longword access split into two halves
// (R06) All control registers clear on reset, standby
// (R07) One filter enable per subblock, A+B
// (R08) Enabled filter applies shared cancel mode
// (R09) Subsequent mode: pass, mask until match
// (R10) Preceding mode: pass at match unless changed
// (R11) Disabled mid-run subsequent: finish run, masked
// (R12) Disabled mid-run preceding: finish until match/change
// (R13) Bits 7:5 pick clock bus 0-5
// (R14) Bits 4:2 pick measurement mode
// (R15) Rotation mode only on subblocks 12-15; the code accepts it on every subblock
// (R16) Bits 1:0 pick edges on A input
// (R17) Edges from filtered or raw signal
// (R18) High/low mode: falling gives high time
// (R19) PWM/rotation: edge sets cycle, off-duty level
// (R20) Up/down and x4 need both edges
// (R21) B edges only in up/down, x4 modes
// (R22) Irq enable byte, bits 7:4 read zero
// (R23) Enable bits gate C, event, A, capture
// (R24) Overflow irq is OR of enabled flags
module pit_top
  import pit_pkg::*;
#(
  parameter int NSB = 20,
  parameter int NB = 3,
  parameter int TH_W = 16,
  parameter int PRE_W = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic stby_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NSB-1:0] pin_a_i,
  input wire logic [NB-1:0] pin_b_i,
  input wire logic [NSB-1:0] ovf_a_flag_i,
  input wire logic [NSB-1:0] ovf_b_flag_i,
  input wire logic [NSB-1:0] ovf_c_flag_i,
  input wire logic [NSB-1:0] cap_flag_i,
  output logic [NSB-1:0] cnt_tick_o,
  output logic [NSB-1:0] edge_a_o,
  output logic [NB-1:0] edge_b_o,
  output logic [NSB-1:0] level_gate_o,
  output logic [NSB-1:0] ovf_irq_o,
  output logic [NSB-1:0] cap_irq_o
);
  localparam int NIN = NSB + NB;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [NSB-1:0] merge20(input logic [NSB-1:0] old,
                                             input logic [31:0] dat, input logic [31:0] m);
    logic [31:0] t;
    t = ({{(32-NSB){1'b0}}, old} & ~m) | (dat & m);
    return t[NSB-1:0];
  endfunction

  function automatic logic bus_tick(input logic [PRE_W-1:0] pre, input logic [2:0] ck);
    logic [PRE_W-1:0] m;
    m = PRE_W'((1 << ck) - 1);
    return (ck <= `PIT_CK_LAST) && ((pre & m) == m);
  endfunction

  function automatic logic pick_edge(input logic [1:0] eg, input logic r, input logic f);
    case (eg)
      `PIT_EG_RISE: return r;
      `PIT_EG_FALL: return f;
      `PIT_EG_BOTH: return r | f;
      default: return 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [NSB-1:0] start_q;
  logic [NSB-1:0] ncen_q;
  logic [1:0] gctl_q;
  logic [TH_W-1:0] thr_q [NSB];
  logic [7:0] mctl_q [NSB];
  logic [3:0] ien_q [NSB];
  pit_phase_type ph_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rdata;
  logic req;
  logic lo_we;
  logic hi_we;
  logic [31:0] wm;
  logic [3:0] region;
  logic [5:0] gix;
  logic [4:0] sb;
  logic sb_ok;

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign lo_we = req && wb_we_i && (ph_q == PH_LOW);
  assign hi_we = req && wb_we_i && (ph_q == PH_HIGH);
  assign region = wb_adr_i[11:8];
  assign gix = wb_adr_i[7:2];
  assign sb = wb_adr_i[6:2];
  assign sb_ok = !wb_adr_i[7] && (sb < 5'(NSB));
  // Only the lanes of the active half are written in a given cycle
  assign wm = lo_we ? {16'h0000, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} :
              hi_we ? {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, 16'h0000} : 32'h0000_0000; // R05

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // Every access takes two phases so halves never meet in one cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ph_q <= PH_LOW;
      ack_q <= 1'b0;
    end else begin
      ack_q <= 1'b0;
      if (req) begin
        case (ph_q)
          PH_LOW: ph_q <= PH_HIGH; // R05
          PH_HIGH: begin
            ph_q <= PH_LOW;
            ack_q <= 1'b1;
          end
          default: ph_q <= PH_LOW;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dat_q <= `PIT_RST_W32;
    end else if (req && ph_q == PH_LOW) begin
      dat_q[15:0] <= rdata[15:0]; // R05
    end else if (req) begin
      dat_q[31:16] <= rdata[31:16];
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ----------------------------------------
  // Global registers
  // ----------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      start_q <= '0;
      ncen_q <= '0;
      gctl_q <= '0;
    end else if (stby_i) begin
      start_q <= '0; // R06
      ncen_q <= '0;
      gctl_q <= '0;
    end else if (region == `PIT_RG_GLB) begin
      if (gix == `PIT_IX_START) begin
        start_q <= merge20(start_q, wb_dat_i, wm); // R02
      end
      if (gix == `PIT_IX_NCEN) begin
        ncen_q <= merge20(ncen_q, wb_dat_i, wm); // R07
      end
      if (gix == `PIT_IX_GCTL && lo_we && wb_sel_i[0]) begin
        gctl_q <= wb_dat_i[1:0];
      end
    end
  end

  // ----------------------------------------
  // Per-subblock registers
  // ----------------------------------------
  // Byte registers take lane 0 only; other lanes are dropped
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NSB; i++) begin
        thr_q[i] <= '0;
        mctl_q[i] <= `PIT_RST_B8;
        ien_q[i] <= `PIT_RST_IE;
      end
    end else if (stby_i) begin
      for (int i = 0; i < NSB; i++) begin
        thr_q[i] <= '0;
        mctl_q[i] <= `PIT_RST_B8; // R06
        ien_q[i] <= `PIT_RST_IE;
      end
    end else if (lo_we && sb_ok) begin
      for (int i = 0; i < NSB; i++) begin
        if (sb == 5'(i)) begin
          if (region == `PIT_RG_THR) begin
            thr_q[i] <= (thr_q[i] & ~wm[TH_W-1:0]) | (wb_dat_i[TH_W-1:0] & wm[TH_W-1:0]);
          end
          if (region == `PIT_RG_MCTL && wb_sel_i[0]) begin
            mctl_q[i] <= wb_dat_i[7:0]; // R13 R14 R16
          end
          if (region == `PIT_RG_IEN && wb_sel_i[0]) begin
            ien_q[i] <= wb_dat_i[3:0]; // R22
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [NSB-1:0] lvl_a;
  logic [NSB-1:0] run;

  always_comb begin
    rdata = 32'h0000_0000;
    case (region)
      `PIT_RG_GLB: begin
        case (gix)
          `PIT_IX_START: rdata[NSB-1:0] = start_q; // R02
          `PIT_IX_NCEN: rdata[NSB-1:0] = ncen_q;
          `PIT_IX_GCTL: rdata[1:0] = gctl_q;
          `PIT_IX_LVL: rdata[NSB-1:0] = lvl_a;
          `PIT_IX_RUN: rdata[NSB-1:0] = run;
          default: rdata = 32'h0000_0000;
        endcase
      end
      `PIT_RG_THR: if (sb_ok) begin
        rdata[TH_W-1:0] = thr_q[sb];
      end
      `PIT_RG_MCTL: if (sb_ok) begin
        rdata[7:0] = mctl_q[sb];
      end
      `PIT_RG_IEN: if (sb_ok) begin
        rdata[3:0] = ien_q[sb]; // R22
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // Prescaler and count gating
  // ----------------------------------------
  // Never cleared by a start, so the first tick may lag one bus period
  logic [PRE_W-1:0] pre_q;
  logic [NSB-1:0] tick_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1; // R04
    end
  end

  assign run = start_q & {NSB{gctl_q[`PIT_GC_EN]}}; // R01

  // Counters see no tick while stopped and therefore keep their value
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_q <= '0;
    end else begin
      for (int i = 0; i < NSB; i++) begin
        tick_q[i] <= run[i] && bus_tick(pre_q, mctl_q[i][`PIT_CK_HI:`PIT_CK_LO]); // R01 R03 R13
      end
    end
  end

  assign cnt_tick_o = tick_q;

  // ----------------------------------------
  // Input synchronisers and filters
  // ----------------------------------------
  logic [NIN-1:0] s1_q;
  logic [NIN-1:0] s2_q;
  logic [NIN-1:0] s3_q;
  logic [NIN-1:0] st_q;
  logic [NIN-1:0] filt;
  logic [NIN-1:0] busy;
  logic [NIN-1:0] lvl;
  logic [NIN-1:0] lvl_q;

  // A change counts only once the second and third stages agree
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      st_q <= '0;
    end else begin
      s1_q <= {pin_b_i, pin_a_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NIN; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          st_q[i] <= s3_q[i];
        end
      end
    end
  end

  for (genvar g = 0; g < NIN; g++) begin : g_filt
    localparam int SB = (g < NSB) ? g : g - NSB;
    pit_noise_filter #(
      .TH_W(TH_W)
    ) u_filt (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .clr_i(stby_i),
      .din_i(st_q[g]),
      .en_i(ncen_q[SB]), // R07
      .pre_i(gctl_q[`PIT_GC_PRE]), // R08
      .thr_i(thr_q[SB]),
      .dout_o(filt[g]),
      .busy_o(busy[g])
    );
    // A run left over after disable still owns the signal until it ends
    assign lvl[g] = (ncen_q[SB] || busy[g]) ? filt[g] : st_q[g]; // R17
  end

  assign lvl_a = lvl[NSB-1:0];

  // ----------------------------------------
  // Edge detection and level gate
  // ----------------------------------------
  logic [NSB-1:0] ea_q;
  logic [NB-1:0] eb_q;
  logic [NSB-1:0] gate_q;
  logic [NIN-1:0] rise;
  logic [NIN-1:0] fall;

  assign rise = lvl & ~lvl_q;
  assign fall = ~lvl & lvl_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lvl_q <= '0;
      ea_q <= '0;
      eb_q <= '0;
      gate_q <= '0;
    end else begin
      lvl_q <= lvl;
      for (int i = 0; i < NSB; i++) begin
        ea_q[i] <= run[i] && pick_edge(mctl_q[i][`PIT_EG_HI:`PIT_EG_LO], rise[i], fall[i]); // R16
        case (mctl_q[i][`PIT_MD_HI:`PIT_MD_LO])
          `PIT_MD_HILO, `PIT_MD_PWM, `PIT_MD_ROT: begin
            case (mctl_q[i][`PIT_EG_HI:`PIT_EG_LO])
              `PIT_EG_RISE: gate_q[i] <= run[i] && !lvl[i]; // R18 R19
              `PIT_EG_FALL: gate_q[i] <= run[i] && lvl[i]; // R18 R19
              default: gate_q[i] <= 1'b0;
            endcase
          end
          default: gate_q[i] <= 1'b0; // R14
        endcase
      end
      for (int i = 0; i < NB; i++) begin
        case (mctl_q[i][`PIT_MD_HI:`PIT_MD_LO])
          `PIT_MD_UPDN, `PIT_MD_X4: eb_q[i] <= run[i] && (rise[NSB+i] || fall[NSB+i]); // R21
          default: eb_q[i] <= 1'b0; // R21
        endcase
      end
    end
  end

  assign edge_a_o = ea_q;
  assign edge_b_o = eb_q;
  assign level_gate_o = gate_q;

  // ----------------------------------------
  // Interrupt gating
  // ----------------------------------------
  logic [NSB-1:0] ovf_q;
  logic [NSB-1:0] cap_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_q <= '0;
      cap_q <= '0;
    end else begin
      for (int i = 0; i < NSB; i++) begin
        ovf_q[i] <= (ovf_c_flag_i[i] && ien_q[i][`PIT_IE_C]) ||
                    (ovf_b_flag_i[i] && ien_q[i][`PIT_IE_B]) ||
                    (ovf_a_flag_i[i] && ien_q[i][`PIT_IE_A]); // R23 R24
        cap_q[i] <= cap_flag_i[i] && ien_q[i][`PIT_IE_CAP]; // R23
      end
    end
  end

  assign ovf_irq_o = ovf_q;
  assign cap_irq_o = cap_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_run;
    cnt_tick_o[0] |-> $past(start_q[0]) && $past(gctl_q[`PIT_GC_EN]);
  endproperty
  a_run: assert property (p_run) else $error("tick without run"); // R01

  property p_rsv;
    wb_ack_o && region == `PIT_RG_GLB && gix == `PIT_IX_START |-> wb_dat_o[31:20] == 12'h000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("start upper bits not zero"); // R02

  property p_split;
    wb_ack_o |-> $past(ph_q) == PH_HIGH && $past(ph_q, 2) == PH_LOW;
  endproperty
  a_split: assert property (p_split) else $error("access not split"); // R05

  property p_stby;
    stby_i |=> start_q == '0 && ncen_q == '0 && mctl_q[0] == `PIT_RST_B8 && ien_q[0] == '0;
  endproperty
  a_stby: assert property (p_stby) else $error("standby did not clear"); // R06

  // The edge that releases reset still holds the prescaler, so skip it
  property p_pre;
    !$past(rst_i) |-> pre_q == PRE_W'($past(pre_q) + 1'b1);
  endproperty
  a_pre: assert property (p_pre) else $error("prescaler stalled"); // R04

  property p_bedge;
    edge_b_o[0] |-> $past(mctl_q[0][`PIT_MD_HI]) && $past(mctl_q[0][`PIT_MD_HI-1]);
  endproperty
  a_bedge: assert property (p_bedge) else $error("B edge outside count modes"); // R21

  property p_noedge;
    $past(mctl_q[0][`PIT_EG_HI:`PIT_EG_LO]) == `PIT_EG_NONE |-> !edge_a_o[0];
  endproperty
  a_noedge: assert property (p_noedge) else $error("edge with sensing off"); // R16

  property p_ovf;
    ##1 1'b1 |-> ovf_irq_o[0] == $past((ovf_a_flag_i[0] && ien_q[0][`PIT_IE_A]) ||
                  (ovf_b_flag_i[0] && ien_q[0][`PIT_IE_B]) ||
                  (ovf_c_flag_i[0] && ien_q[0][`PIT_IE_C]));
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow irq mismatch"); // R24

  property p_ien;
    wb_ack_o && region == `PIT_RG_IEN |-> wb_dat_o[31:4] == 28'h000_0000;
  endproperty
  a_ien: assert property (p_ien) else $error("irq enable reserved bits set"); // R22

  c_split_wr: cover property (hi_we && wb_sel_i == 4'hf);
  c_b_edge: cover property (edge_b_o[0]);
  c_tick: cover property (cnt_tick_o[0] ##1 !run[0]);
endmodule // pit_top

// [bench/pit_pulse_src.sv]
`timescale 1ns/1ps
module pit_pulse_src (
  input wire logic mclk_i,
  output logic [19:0] pin_a_o,
  output logic [2:0] pin_b_o
);
  // ----------------------------------------
  // External pulse source
  // ----------------------------------------
  // Pins always driven: a sensor output never floats, so no released state
  initial begin
    pin_a_o = 20'h0_0000;
    pin_b_o = 3'h0;
  end

  task automatic set_a(input int n, input logic v);
    @(posedge mclk_i);
    pin_a_o[n] <= v;
  endtask

  task automatic set_b(input int n, input logic v);
    @(posedge mclk_i);
    pin_b_o[n] <= v;
  endtask

  // Short inverted pulse of w cycles, the noise a filter must judge
  task automatic glitch_a(input int n, input int w);
    @(posedge mclk_i);
    pin_a_o[n] <= ~pin_a_o[n];
    repeat (w) @(posedge mclk_i);
    pin_a_o[n] <= ~pin_a_o[n];
  endtask
endmodule // pit_pulse_src

// [bench/pit_top_tb.sv]
`timescale 1ns/1ps
`include "pit_map.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module pit_top_tb
  import pit_pkg::*;
;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic stby_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic [19:0] pin_a;
  logic [2:0] pin_b;
  logic [3:0] fl = 4'h0;
  logic [19:0] tick, ea, gate, oirq, cirq;
  logic [2:0] eb;
  logic [31:0] q;
  int errors = 0;
  int samples_checked = 0;
  // Four-state counters, so an unknown pulse output shows up as a mismatch
  integer ta = 0;
  integer tb1 = 0;
  integer na = 0;
  integer nb = 0;
  integer c0, c1;
  int lv;
  int ea_exp[4] = '{0, 1, 1, 2};
  int md[3] = '{2, 4, 5};

  always #4 mclk_i = ~mclk_i;

  always @(posedge mclk_i) begin
    ta <= ta + tick[0];
    tb1 <= tb1 + tick[1];
    na <= na + ea[0];
    nb <= nb + eb[0];
  end

  pit_top DUT (
    .mclk_i(mclk_i), .rst_i(rst_i), .stby_i(stby_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pin_a_i(pin_a), .pin_b_i(pin_b),
    .ovf_a_flag_i({16'h0000, fl[1], 3'h0}), .ovf_b_flag_i({16'h0000, fl[2], 3'h0}),
    .ovf_c_flag_i({16'h0000, fl[3], 3'h0}), .cap_flag_i({16'h0000, fl[0], 3'h0}),
    .cnt_tick_o(tick), .edge_a_o(ea), .edge_b_o(eb), .level_gate_o(gate),
    .ovf_irq_o(oirq), .cap_irq_o(cirq)
  );

  pit_pulse_src src (.mclk_i(mclk_i), .pin_a_o(pin_a), .pin_b_o(pin_b));

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge mclk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge mclk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000, 4'hF);
    `CHK(q, e)
  endtask

  task automatic final_report;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  // Whole sequence needs about 1000 cycles; generous margin
  initial begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    $display("[FAIL] %0t run did not finish", $time);
    final_report;
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd_chk(12'h000, 32'h0000_0000);
    rd_chk(12'h004, 32'h0000_0000);
    rd_chk(12'h008, 32'h0000_0000);
    rd_chk(12'h24C, 32'h0000_0000);
    rd_chk(12'h34C, 32'h0000_0000);
    wr(12'h000, 32'hFFFF_FFFF);
    rd_chk(12'h000, 32'h000F_FFFF);
    wb(1'b1, 12'h000, 32'h0000_0000, 4'h3);
    rd_chk(12'h000, 32'h000F_0000);
    wb(1'b1, 12'h004, 32'hFFFF_FFFF, 4'hC);
    rd_chk(12'h004, 32'h000F_0000);
    wr(12'h004, 32'h0000_0000);
    wr(12'h0F0, 32'h1234_5678);
    rd_chk(12'h0F0, 32'h0000_0000);
    // Clock code 101 only; 110 and 111 are never written
    wr(12'h23C, 32'h0000_00B7);
    rd_chk(12'h23C, 32'h0000_00B7);
    wr(12'h34C, 32'h0000_00FF);
    rd_chk(12'h34C, 32'h0000_000F);
    // Run gating and clock buses: subblock 0 on bus 0, 1 on bus 5
    wr(12'h204, 32'h0000_00A0);
    wr(12'h000, 32'h0000_1003);
    rd_chk(12'h010, 32'h0000_0000);
    c0 = ta;
    repeat (64) @(posedge mclk_i);
    `CHK(ta - c0, 0)
    wr(12'h008, 32'h0000_0001);
    rd_chk(12'h010, 32'h0000_1003);
    c0 = ta;
    c1 = tb1;
    repeat (64) @(posedge mclk_i);
    `CHK(ta - c0, 64)
    `CHK(tb1 - c1, 64 >> 5)
    wr(12'h000, 32'h0000_1002);
    repeat (4) @(posedge mclk_i);
    c0 = ta;
    repeat (64) @(posedge mclk_i);
    `CHK(ta - c0, 0)
    wr(12'h000, 32'h0000_1003);
    // Edge sense codes on A, B silent outside modes 110/111
    for (int e = 0; e < 4; e++) begin
      wr(12'h200, 32'(e));
      c0 = na;
      c1 = nb;
      src.set_a(0, 1'b1);
      repeat (12) @(posedge mclk_i);
      src.set_a(0, 1'b0);
      src.set_b(0, 1'b1);
      repeat (12) @(posedge mclk_i);
      src.set_b(0, 1'b0);
      repeat (12) @(posedge mclk_i);
      `CHK(na - c0, ea_exp[e])
      `CHK(nb - c1, 0)
    end
    for (int m = 6; m < 8; m++) begin
      wr(12'h200, 32'((m << 2) | 3));
      c1 = nb;
      src.set_b(0, 1'b1);
      repeat (12) @(posedge mclk_i);
      src.set_b(0, 1'b0);
      repeat (12) @(posedge mclk_i);
      `CHK(nb - c1, 2)
    end
    // Level gate on subblock 12, the only range allowed rotation mode
    for (lv = 1; lv >= 0; lv--) begin
      src.set_a(12, 1'(lv));
      for (int i = 0; i < 3; i++) begin
        for (int e = 1; e < 3; e++) begin
          wr(12'h230, 32'((md[i] << 2) | e));
          repeat (8) @(posedge mclk_i);
          `CHK(gate[12], 1'((e == 2) == (lv == 1)))
        end
      end
    end
    // Interrupt gating on subblock 3
    for (int i = 0; i < 2; i++) begin
      wr(12'h30C, i == 0 ? 32'h0000_000A : 32'h0000_0005);
      for (int k = 0; k < 4; k++) begin
        @(posedge mclk_i);
        fl <= 4'h1 << k;
        repeat (3) @(posedge mclk_i);
        `CHK(oirq[3], 1'(k != 0 && ((i == 0) == (k % 2 == 1))))
        `CHK(cirq[3], 1'(k == 0 && i == 1))
      end
    end
    fl <= 4'h0;
    // Filter on subblock 0, both edges, threshold 20
    wr(12'h200, 32'h0000_0003);
    wr(12'h100, 32'h0000_0014);
    wr(12'h004, 32'h0000_0001);
    c0 = na;
    src.set_a(0, 1'b1);
    repeat (4) @(posedge mclk_i);
    src.glitch_a(0, 2);
    repeat (40) @(posedge mclk_i);
    `CHK(na - c0, 1)
    wr(12'h008, 32'h0000_0003);
    c0 = na;
    src.set_a(0, 1'b0);
    repeat (40) @(posedge mclk_i);
    `CHK(na - c0, 1)
    rd_chk(12'h00C, 32'h0000_0000);
    c0 = na;
    src.glitch_a(0, 3);
    repeat (40) @(posedge mclk_i);
    `CHK(na - c0, 0)
    wr(12'h004, 32'h0000_0000);
    c0 = na;
    src.glitch_a(0, 3);
    repeat (20) @(posedge mclk_i);
    `CHK(na - c0, 2)
    // Enable dropped while a subsequent-mode run is counting
    wr(12'h008, 32'h0000_0001);
    wr(12'h004, 32'h0000_0001);
    c0 = na;
    src.set_a(0, 1'b1);
    // Let the change clear the synchroniser and start the run first
    repeat (6) @(posedge mclk_i);
    wr(12'h004, 32'h0000_0000);
    src.glitch_a(0, 2);
    repeat (40) @(posedge mclk_i);
    `CHK(na - c0, 1)
    // Standby entry clears the control registers
    stby_i <= 1'b1;
    @(posedge mclk_i);
    stby_i <= 1'b0;
    rd_chk(12'h000, 32'h0000_0000);
    rd_chk(12'h008, 32'h0000_0000);
    rd_chk(12'h23C, 32'h0000_0000);
    final_report;
  end
endmodule // pit_top_tb
